// ### core/serial_bus_pkg.sv
// Purpose: shared constants and types of the two-wire sequence controller
// Assumes: APB register access, 32-bit data, one word per register
// Notes: control bit positions match the low six bits of the control register

package serial_bus_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned addr_w = 8;
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [31:0] word_zero = 32'h0000_0000;

  // ****************************************
  // control fields
  // ****************************************
  localparam int unsigned req_w = 5;
  localparam int unsigned start_bit = 0;
  localparam int unsigned restart_bit = 1;
  localparam int unsigned stop_bit = 2;
  localparam int unsigned rx_bit = 3;
  localparam int unsigned ack_req_bit = 4;
  localparam int unsigned ack_value_bit = 5;

  // ****************************************
  // status fields
  // ****************************************
  localparam int unsigned rx_byte_lsb = 0;
  localparam int unsigned busy_bit = 8;
  localparam int unsigned rx_ctx_bit = 9;

  // ****************************************
  // link timing
  // ****************************************
  localparam int unsigned tick_w = 16;
  localparam logic [1:0] phase_first = 2'h0;
  localparam logic [1:0] stretch_phase = 2'h1;
  localparam logic [1:0] sample_phase = 2'h2;
  localparam logic [1:0] phase_last = 2'h3;
  localparam logic [2:0] bits_first = 3'h0;
  localparam logic [2:0] bits_last = 3'h7;

  typedef enum logic [5:0] {
    st_idle    = 6'h01,
    st_start   = 6'h02,
    st_restart = 6'h04,
    st_stop    = 6'h08,
    st_rx      = 6'h10,
    st_ack     = 6'h20
  } link_state_e;

  // pin pull-downs: a one pulls the open-drain line low
  typedef struct packed {
    logic sda_low;
    logic scl_low;
  } pull_s;

  typedef struct packed {
    logic [req_w-1:0] req;
    logic ack_value;
    logic req_tgl;
    logic done_seen;
    logic rx_ctx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_state_s;

  typedef struct packed {
    link_state_e st;
    logic req_seen;
    logic done_tgl;
    logic [1:0] phase;
    logic [tick_w-1:0] tick;
    logic [2:0] bits;
    logic [7:0] shift;
    pull_s pull;
  } link_reg_s;

endpackage

// ### core/bit_sync.sv
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: asynchronous active-low reset
// Notes: the first stage feeds only the second stage

`timescale 1ns/1ps

module bit_sync #(
  parameter int unsigned width = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);

  typedef struct packed {
    logic [width-1:0] meta;
    logic [width-1:0] safe;
  } sync_s;

  sync_s cur_ff;
  sync_s nxt_sync;

  always_comb begin
    nxt_sync.meta = d;
    nxt_sync.safe = cur_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_sync;
    end
  end

  assign q = cur_ff.safe;

endmodule

// ### core/serial_bus_master.sv
// Purpose: master sequence engine of a two-wire serial bus behind APB
// Assumes: link_clk runs free; both lines are open drain with pull-ups
// Notes: one sequence at a time; each bit is four phases of link_clk ticks
//
// Function
// - ack value one sends not-acknowledge, zero sends acknowledge.
// - ack controls act only as master while receiving from a slave.
// - writing one to ack request runs an ack sequence with ack value.
// - ack request bit clears itself when the ack sequence ends.
// - receive request reads one byte; clears after the eighth bit.
// - stop request drives a stop condition; clears when it ends.
// - restart request drives a repeated start; clears when it ends.
// - start request drives a start condition; clears when it ends.
// - the accepted request bit reads one from its write until the link reports the end.

`timescale 1ns/1ps

module serial_bus_master #(
  parameter int unsigned phase_cycles = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_bus_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe
);

  // ****************************************
  // crossing signals
  // ****************************************
  serial_bus_pkg::apb_state_s apb_ff;
  serial_bus_pkg::apb_state_s nxt_apb;
  serial_bus_pkg::link_reg_s link_ff;
  serial_bus_pkg::link_reg_s nxt_link;

  logic done_sync;
  logic req_sync;
  logic sda_sync;
  logic scl_sync;

  localparam logic [serial_bus_pkg::tick_w-1:0] tick_last =
    serial_bus_pkg::tick_w'(phase_cycles - 1);

  bit_sync #(
    .width(1)
  ) u_done_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link_ff.done_tgl),
    .q(done_sync)
  );

  bit_sync #(
    .width(3)
  ) u_link_sync (
    .clk(link_clk),
    .rst_n(presetn),
    .d({apb_ff.req_tgl, serial_data_line_in, serial_clock_line_in}),
    .q({req_sync, sda_sync, scl_sync})
  );

  // ****************************************
  // register side
  // ****************************************
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic [serial_bus_pkg::req_w-1:0] wr_req;
  logic [serial_bus_pkg::req_w-1:0] pick;
  logic done_evt;

  assign setup = psel && !penable;
  assign access = psel && penable && apb_ff.pready;
  assign hit_ctrl = (paddr == serial_bus_pkg::ctrl_offset);
  assign hit_status = (paddr == serial_bus_pkg::status_offset);
  assign done_evt = (done_sync != apb_ff.done_seen);

  always_comb begin
    wr_req = pwdata[serial_bus_pkg::req_w-1:0];
    // acknowledge only makes sense right after a received byte
    if (!apb_ff.rx_ctx) begin
      wr_req[serial_bus_pkg::ack_req_bit] = 1'b0;
    end
    // several bits in one write: keep the lowest, drop the rest
    pick = wr_req & (~wr_req + serial_bus_pkg::req_w'(1));
  end

  always_comb begin
    nxt_apb = apb_ff;
    nxt_apb.pready = setup;
    nxt_apb.pslverr = setup && !hit_ctrl && !hit_status;
    nxt_apb.prdata = serial_bus_pkg::word_zero;
    if (setup && hit_ctrl) begin
      nxt_apb.prdata[serial_bus_pkg::req_w-1:0] = apb_ff.req;
      nxt_apb.prdata[serial_bus_pkg::ack_value_bit] = apb_ff.ack_value;
    end else if (setup && hit_status) begin
      nxt_apb.prdata[serial_bus_pkg::rx_byte_lsb +: 8] = link_ff.shift;
      nxt_apb.prdata[serial_bus_pkg::busy_bit] = |apb_ff.req;
      nxt_apb.prdata[serial_bus_pkg::rx_ctx_bit] = apb_ff.rx_ctx;
    end
    if (done_evt) begin
      nxt_apb.done_seen = done_sync;
      // clears every request bit once the link reports the end
      nxt_apb.req = '0;
      if (apb_ff.req[serial_bus_pkg::rx_bit]) begin
        nxt_apb.rx_ctx = 1'b1;
      end else if (!apb_ff.req[serial_bus_pkg::ack_req_bit]) begin
        nxt_apb.rx_ctx = 1'b0;
      end
    end
    if (access && pwrite && hit_ctrl) begin
      // ack value is held steady while a sequence runs on the link
      if (apb_ff.req == '0) begin
        nxt_apb.ack_value = pwdata[serial_bus_pkg::ack_value_bit];
      end
      // a new request is refused while one is pending
      if (apb_ff.req == '0 && pick != '0) begin
        nxt_apb.req = pick;
        nxt_apb.req_tgl = !apb_ff.req_tgl;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_ff <= '0;
    end else begin
      apb_ff <= nxt_apb;
    end
  end

  assign prdata = apb_ff.prdata;
  assign pready = apb_ff.pready;
  assign pslverr = apb_ff.pslverr;

  // ****************************************
  // link side
  // ****************************************
  // pull-downs per sequence and phase; a start begins with both lines free
  function automatic serial_bus_pkg::pull_s pulls(
    input serial_bus_pkg::link_state_e st,
    input logic [1:0] ph,
    input logic av
  );
    serial_bus_pkg::pull_s p;
    p = '0;
    unique case (st)
      serial_bus_pkg::st_start: begin
        p.sda_low = (ph != serial_bus_pkg::phase_first);
        p.scl_low = (ph == serial_bus_pkg::phase_last);
      end
      serial_bus_pkg::st_restart: begin
        p.sda_low = (ph >= serial_bus_pkg::sample_phase);
        p.scl_low = (ph == serial_bus_pkg::phase_first) ||
          (ph == serial_bus_pkg::phase_last);
      end
      serial_bus_pkg::st_stop: begin
        p.sda_low = (ph != serial_bus_pkg::phase_last);
        p.scl_low = (ph == serial_bus_pkg::phase_first);
      end
      serial_bus_pkg::st_rx: begin
        p.sda_low = 1'b0;
        p.scl_low = (ph == serial_bus_pkg::phase_first) ||
          (ph == serial_bus_pkg::phase_last);
      end
      serial_bus_pkg::st_ack: begin
        // one releases the line (not-acknowledge), zero pulls it low
        p.sda_low = !av;
        p.scl_low = (ph == serial_bus_pkg::phase_first) ||
          (ph == serial_bus_pkg::phase_last);
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction

  logic req_evt;
  logic phase_end;
  logic stretched;
  logic seq_end;

  assign req_evt = (req_sync != link_ff.req_seen);
  // a slave holding the clock low stretches the high phase
  assign stretched = (link_ff.phase == serial_bus_pkg::stretch_phase) && !scl_sync;
  assign phase_end = (link_ff.tick == tick_last) && !stretched;
  assign seq_end = phase_end && (link_ff.phase == serial_bus_pkg::phase_last) &&
    ((link_ff.st != serial_bus_pkg::st_rx) ||
     (link_ff.bits == serial_bus_pkg::bits_last));

  always_comb begin
    nxt_link = link_ff;
    unique case (link_ff.st)
      serial_bus_pkg::st_idle: begin
        // request bits are stable until done returns, so they cross safely
        if (req_evt) begin
          nxt_link.req_seen = req_sync;
          nxt_link.phase = serial_bus_pkg::phase_first;
          nxt_link.tick = '0;
          nxt_link.bits = serial_bus_pkg::bits_first;
          if (apb_ff.req[serial_bus_pkg::start_bit]) begin
            nxt_link.st = serial_bus_pkg::st_start;
          end else if (apb_ff.req[serial_bus_pkg::restart_bit]) begin
            nxt_link.st = serial_bus_pkg::st_restart;
          end else if (apb_ff.req[serial_bus_pkg::stop_bit]) begin
            nxt_link.st = serial_bus_pkg::st_stop;
          end else if (apb_ff.req[serial_bus_pkg::rx_bit]) begin
            nxt_link.st = serial_bus_pkg::st_rx;
          end else if (apb_ff.req[serial_bus_pkg::ack_req_bit]) begin
            nxt_link.st = serial_bus_pkg::st_ack;
          end else begin
            nxt_link.done_tgl = !link_ff.done_tgl;
          end
          nxt_link.pull = pulls(nxt_link.st, serial_bus_pkg::phase_first,
            apb_ff.ack_value);
        end
      end
      serial_bus_pkg::st_start, serial_bus_pkg::st_restart,
      serial_bus_pkg::st_stop, serial_bus_pkg::st_rx,
      serial_bus_pkg::st_ack: begin
        if (!phase_end) begin
          if (!stretched) begin
            nxt_link.tick = link_ff.tick + serial_bus_pkg::tick_w'(1);
          end
        end else begin
          nxt_link.tick = '0;
          nxt_link.phase = link_ff.phase + 2'h1;
          if (link_ff.st == serial_bus_pkg::st_rx &&
              link_ff.phase == serial_bus_pkg::sample_phase) begin
            nxt_link.shift = {link_ff.shift[6:0], sda_sync};
          end
          if (link_ff.phase == serial_bus_pkg::phase_last &&
              link_ff.st == serial_bus_pkg::st_rx && !seq_end) begin
            nxt_link.bits = link_ff.bits + 3'h1;
          end
          if (seq_end) begin
            // the line levels of the last phase stay until the next sequence
            nxt_link.st = serial_bus_pkg::st_idle;
            nxt_link.done_tgl = !link_ff.done_tgl;
          end else begin
            nxt_link.pull = pulls(link_ff.st, nxt_link.phase, apb_ff.ack_value);
          end
        end
      end
      default: begin
        nxt_link.st = serial_bus_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      link_ff <= '{st: serial_bus_pkg::st_idle, default: '0};
    end else begin
      link_ff <= nxt_link;
    end
  end

  // ****************************************
  // open-drain pins
  // ****************************************
  logic [1:0] low_ff;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      low_ff <= 2'h0;
    end else begin
      low_ff <= {nxt_link.pull.sda_low, nxt_link.pull.scl_low};
    end
  end

  assign serial_data_line_out = 1'b0;
  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_oe = low_ff[1];
  assign serial_clock_line_oe = low_ff[0];

endmodule

// ### test/serial_bus_master_asserts.sv
// Purpose: port checks of the sequence engine
// Assumes: phase_cycles small, a start ends within 64 link_clk
// Notes: bound to every engine instance
`timescale 1ns/1ps
module serial_bus_master_asserts #(
  parameter int unsigned phase_cycles = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [serial_bus_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_clk,
  input wire logic serial_data_line_oe,
  input wire logic serial_clock_line_oe
);
  // ****
  // checks
  // ****
  pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready held too long");
  pready_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !$past(penable) |-> pready) else $error("late answer");
  pready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable) else $error("answer outside access");
  pready_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel) && !$past(penable)) else $error("answer not after setup");
  slverr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> pslverr == (paddr != serial_bus_pkg::ctrl_offset &&
    paddr != serial_bus_pkg::status_offset)) else $error("wrong pslverr");
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0) else $error("read data outside answer");
  start_cond_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(serial_data_line_oe) && !serial_clock_line_oe |-> ##[1:64] serial_clock_line_oe)
    else $error("start not closed by clock low");
  stop_cond_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(serial_data_line_oe) && !serial_clock_line_oe |=> !serial_clock_line_oe [*4])
    else $error("clock pulled after stop");
  cover property (@(posedge pclk) pready && pslverr);
  cover property (@(posedge link_clk) $rose(serial_data_line_oe));
  cover property (@(posedge link_clk) $fell(serial_data_line_oe) && !serial_clock_line_oe);
endmodule
bind serial_bus_master serial_bus_master_asserts #(.phase_cycles(phase_cycles)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
  .serial_data_line_oe(serial_data_line_oe), .serial_clock_line_oe(serial_clock_line_oe));

// ### test/bus_slave_model.sv
// Purpose: behavioural slave that answers master reads
// Assumes: bench resolves both lines with pull-ups
// Notes: stretch holds the clock line low after each fall
`timescale 1ns/1ps
module bus_slave_model (
  input wire logic link_clk,
  input wire logic scl,
  input wire logic en,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  output logic sda_pull,
  output logic scl_pull
);
  logic [3:0] idx = 4'h8;
  logic [2:0] hold = 3'h0;
  logic scl_d = 1'b1;
  // data moves only after a clock fall so the master samples a settled line
  always @(posedge link_clk) begin
    scl_d <= scl;
    if (!en) begin
      idx <= 4'h8;
    end else if (scl_d && !scl && idx != 4'h0) begin
      idx <= idx - 4'h1;
    end
    if (scl_d && !scl && stretch) begin
      hold <= 3'h7;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign sda_pull = en && idx != 4'h0 && !tx_byte[idx - 4'h1];
  assign scl_pull = hold != 3'h0;
endmodule

// ### test/tb_top.sv
// Purpose: random and corner tests of the sequence engine
// Assumes: open-drain lines with pull-ups, slave model on the far side
// Notes: phase_cycles kept at 4
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, link_clk = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, b = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, sda_oe, scl_oe, s_sda, s_scl, last_bit, en = 0, str = 0;
  logic sda_out, scl_out;
  wire sda = !(sda_oe | s_sda);
  wire scl = !(scl_oe | s_scl);
  int n_fail = 0, checks_done = 0, n_start = 0, n_stop = 0, cyc = 0;
  initial forever #4 pclk = !pclk;
  initial begin
    #37;
    forever #80 link_clk = !link_clk;
  end
  serial_bus_master #(.phase_cycles(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .serial_data_line_in(sda),
    .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
    .serial_clock_line_in(scl), .serial_clock_line_out(scl_out),
    .serial_clock_line_oe(scl_oe));
  bus_slave_model partner (.link_clk(link_clk), .scl(scl), .en(en), .stretch(str),
    .tx_byte(b), .sda_pull(s_sda), .scl_pull(s_scl));
  always @(negedge sda) if (scl === 1'b1) n_start++;
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  always @(posedge scl) last_bit = sda;
  function automatic logic exp_err(logic [7:0] a);
    return a != serial_bus_pkg::ctrl_offset && a != serial_bus_pkg::status_offset;
  endfunction
  task print_verdict();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(string n, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task run(logic [5:0] v);
    int i;
    apb(1, 8'h00, {26'h0, v});
    apb(0, 8'h00, 0);
    chk("req set", {27'h0, v[4:0]}, {27'h0, r[4:0]});
    i = 0;
    do begin
      apb(0, 8'h00, 0);
      i++;
    end while (r[4:0] !== 5'h0 && i < 3000);
    chk("req clear", 0, {27'h0, r[4:0]});
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'hb64c));
    repeat (2) @(posedge link_clk);
    @(posedge pclk);
    presetn <= 1;
    n_start = 0;
    n_stop = 0;
    apb(0, 8'h00, 0);
    chk("ctrl reset", 0, r);
    apb(0, 8'h04, 0);
    chk("busy", 0, r[8]);
    repeat (4) begin
      b = 8'h08 + 8'(($urandom % 60) * 4);
      apb(0, b, 0);
      chk("pslverr", exp_err(b), e);
    end
    run(6'h01);
    chk("starts", 1, n_start);
    apb(1, 8'h00, 32'h10);
    apb(0, 8'h00, 0);
    chk("ack refused", 0, r[4:0]);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'($urandom) : 8'h81;
      en <= 1;
      str <= k[0];
      run(6'h08);
      en <= 0;
      str <= 0;
      apb(0, 8'h04, 0);
      chk("rx byte", b, r[7:0]);
      run({k[0], 5'h10});
      chk("ack bit", k, last_bit);
    end
    run(6'h02);
    chk("restarts", 2, n_start);
    run(6'h04);
    chk("stops", 1, n_stop);
    // open-drain pins may only ever drive low
    chk("pin drive", 0, {30'h0, sda_out, scl_out});
    print_verdict();
  end
endmodule
